// ==== common/dotpf_pkg.sv ====
/*
  Shared definitions for the digital output timing engine: register map,
  field layouts, reset values, mode encodings and filter timing counts.
  Assumes a 100 MHz core clock and one-cycle timebase tick strobes.
*/
package dotpf_pkg;

  localparam int NUM_TERM = 4;
  localparam int NUM_LINES = 8;
  localparam int ADDR_W = 12;

  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_CLK_CFG = 12'h004;
  localparam logic [11:0] OFF_DIVISOR = 12'h008;
  localparam logic [11:0] OFF_START_CFG = 12'h00C;
  localparam logic [11:0] OFF_DELAY = 12'h010;
  localparam logic [11:0] OFF_PAUSE_CFG = 12'h014;
  localparam logic [11:0] OFF_TERM_CFG = 12'h018;
  localparam logic [11:0] OFF_CUSTOM = 12'h01C;
  localparam logic [11:0] OFF_LINE_DIR = 12'h020;
  localparam logic [11:0] OFF_STATUS = 12'h024;

  // control word bit positions (write-only pulses)
  localparam int CTRL_ARM_BIT = 0;
  localparam int CTRL_SW_START_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  localparam int CTRL_HOST_TRIG_BIT = 3;
  // custom filter word positions
  localparam int CUSTOM_N_LSB = 0;
  localparam int CUSTOM_N_W = 10;
  localparam int CUSTOM_CLK_BIT = 16;
  // per-terminal config stride inside the terminal config word
  localparam int TERM_CFG_W = 5;

  typedef enum logic [1:0] {
    CS_TERM = 2'b00, CS_ANALOG = 2'b01, CS_CTR = 2'b10, CS_DIV = 2'b11
  } dotpf_clk_src_t;

  typedef enum logic [1:0] {
    TB_20M = 2'b00, TB_80M = 2'b01, TB_100K = 2'b10, TB_EXT = 2'b11
  } dotpf_tb_sel_t;

  typedef enum logic [2:0] {
    SS_NONE = 3'b000, SS_HOST = 3'b001, SS_TERM = 3'b010,
    SS_AI_REF = 3'b011, SS_AI_START = 3'b100, SS_ANALOG = 3'b101
  } dotpf_start_src_t;

  typedef enum logic [1:0] {
    PS_NONE = 2'b00, PS_TERM = 2'b01, PS_ANALOG = 2'b10, PS_CTR = 2'b11
  } dotpf_pause_src_t;

  typedef enum logic [1:0] {
    FS_SHORT = 2'b00, FS_MEDIUM = 2'b01, FS_LONG = 2'b10, FS_CUSTOM = 2'b11
  } dotpf_flt_set_t;

  typedef enum logic [1:0] {
    OS_INPUT = 2'b00, OS_UPDATE = 2'b01, OS_BEGIN = 2'b10
  } dotpf_out_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_DELAY = 2'b10, ST_RUN = 2'b11
  } dotpf_state_t;

  typedef struct packed {
    logic [1:0] term;
    dotpf_tb_sel_t tb;
    dotpf_clk_src_t src;
  } dotpf_clk_cfg_t;

  typedef struct packed {
    logic [1:0] term;
    logic fall_edge;
    dotpf_start_src_t src;
  } dotpf_start_cfg_t;

  typedef struct packed {
    logic [1:0] term;
    logic pause_low;
    dotpf_pause_src_t src;
  } dotpf_pause_cfg_t;

  typedef struct packed {
    dotpf_out_sel_t out_sel;
    dotpf_flt_set_t setting;
    logic filt_en;
  } dotpf_term_cfg_t;

  localparam dotpf_clk_cfg_t CLK_CFG_RST = 6'h0F;
  localparam logic [15:0] DIVISOR_RST = 16'h0001;
  localparam dotpf_start_cfg_t START_CFG_RST = 6'h00;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam dotpf_pause_cfg_t PAUSE_CFG_RST = 5'h00;
  localparam dotpf_term_cfg_t TERM_CFG_RST = 5'h00;
  localparam logic [9:0] CUSTOM_N_RST = 10'h001;
  localparam logic [7:0] LINE_DIR_RST = 8'h00;

  // filter clock periods and passing widths as printed
  localparam int FLT_PER80_PS = 12500;
  localparam int FLT_PER100K_NS = 10000;
  localparam int FLT_SHORT_PS = 112500;
  localparam int FLT_MEDIUM_PS = 6400000;
  localparam int FLT_LONG_NS = 2560000;
  localparam logic [9:0] FLT_N_SHORT = 10'(FLT_SHORT_PS / FLT_PER80_PS);
  localparam logic [9:0] FLT_N_MEDIUM = 10'(FLT_MEDIUM_PS / FLT_PER80_PS);
  localparam logic [9:0] FLT_N_LONG = 10'(FLT_LONG_NS / FLT_PER100K_NS);

endpackage

// ==== src/dotpf_timing.sv ====
/*
  Digital output timing engine with per-terminal debounce filters and an
  APB register slave. Assumes timebase ticks arrive as one-cycle strobes on
  core_clk and that module-side inputs share core_clk; terminals are async.
*/
// Notes on behaviour
// - start and pause, digital or analog source
// - all task lines update on each clock
// - update clock from terminal, analog, counter, divider
// - timebase is divided, never driven out
// - update clock routable, active high default
// - start on edge, else software start
// - delay to first sample with internal clock
// - start from host, terminal, AI triggers
// - analog start on first configured edge
// - exported start is active high pulse
// - pause suppresses samples at next sample
// - onboard clock resumes at once on release
// - other clocks resume on next edge
// - pause is level, source and level selectable
// - analog pause holds at configured level
// - direction change keeps driven levels glitch-free
// - each terminal input or timing output
// - new level passes after N equal samples
// - short, medium, long and custom settings
// - shorter pulses blocked by same counts
// - per-terminal enable, one filter clock jitter
// - filters disabled after reset
// - falling edges qualified like rising
`timescale 1ns/10ps
`default_nettype none

module dotpf_timing
  import dotpf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tb_20m_tick,
  input wire logic tb_80m_tick,
  input wire logic tb_100k_tick,
  input wire logic analog_cmp_event,
  input wire logic ctr_internal_out,
  input wire logic ai_ref_trig,
  input wire logic ai_start_trig,
  input wire logic [NUM_TERM-1:0] term_in,
  output logic [NUM_TERM-1:0] term_out,
  output logic [NUM_TERM-1:0] term_oe_n,
  input wire logic [NUM_LINES-1:0] sample_data,
  output logic sample_taken,
  output logic [NUM_LINES-1:0] line_out,
  output logic [NUM_LINES-1:0] line_oe_n,
  output logic begin_pulse
);

  ////////////////////////////////////////////////////////////////////////
  // register bus

  dotpf_clk_cfg_t clk_cfg_reg;
  logic [15:0] divisor_reg;
  dotpf_start_cfg_t start_cfg_reg;
  logic [15:0] delay_reg;
  dotpf_pause_cfg_t pause_cfg_reg;
  dotpf_term_cfg_t [NUM_TERM-1:0] term_cfg_reg;
  logic [CUSTOM_N_W-1:0] custom_n_reg;
  logic custom_100k_reg;
  logic [NUM_LINES-1:0] line_dir_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;
  logic rd_hit;
  logic access;
  logic wr;
  logic ctrl_wr;
  logic arm_cmd;
  logic sw_start_cmd;
  logic stop_cmd;
  logic host_trig;
  dotpf_state_t state_reg;
  logic hold_active;
  logic [NUM_TERM-1:0] filt_reg;
  logic [15:0] sample_cnt_reg;

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign ctrl_wr = wr && (paddr == OFF_CTRL);
  assign arm_cmd = ctrl_wr && pwdata[CTRL_ARM_BIT];
  assign sw_start_cmd = ctrl_wr && pwdata[CTRL_SW_START_BIT];
  assign stop_cmd = ctrl_wr && pwdata[CTRL_STOP_BIT];
  assign host_trig = ctrl_wr && pwdata[CTRL_HOST_TRIG_BIT];
  assign pready = 1'b1;
  assign pslverr = access && !rd_hit;
  assign prdata = prdata_reg;

  always_comb begin
    rd_next = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      OFF_CTRL: rd_next = 32'h0000_0000;
      OFF_CLK_CFG: rd_next[5:0] = clk_cfg_reg;
      OFF_DIVISOR: rd_next[15:0] = divisor_reg;
      OFF_START_CFG: rd_next[5:0] = start_cfg_reg;
      OFF_DELAY: rd_next[15:0] = delay_reg;
      OFF_PAUSE_CFG: rd_next[4:0] = pause_cfg_reg;
      OFF_TERM_CFG: rd_next[NUM_TERM*TERM_CFG_W-1:0] = term_cfg_reg;
      OFF_CUSTOM: begin
        rd_next[CUSTOM_N_LSB +: CUSTOM_N_W] = custom_n_reg;
        rd_next[CUSTOM_CLK_BIT] = custom_100k_reg;
      end
      OFF_LINE_DIR: rd_next[NUM_LINES-1:0] = line_dir_reg;
      OFF_STATUS: rd_next = {sample_cnt_reg, 8'h00, filt_reg, 1'b0,
                             hold_active, state_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  // read data captured in the setup cycle so the access phase sees a flop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      prdata_reg <= rd_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_cfg_reg <= CLK_CFG_RST;
      divisor_reg <= DIVISOR_RST;
      start_cfg_reg <= START_CFG_RST;
      delay_reg <= DELAY_RST;
      pause_cfg_reg <= PAUSE_CFG_RST;
      term_cfg_reg <= {NUM_TERM{TERM_CFG_RST}};
      custom_n_reg <= CUSTOM_N_RST;
      custom_100k_reg <= 1'b0;
      line_dir_reg <= LINE_DIR_RST;
    end else if (clk_en && wr) begin
      case (paddr)
        OFF_CLK_CFG: clk_cfg_reg <= pwdata[5:0];
        OFF_DIVISOR: divisor_reg <= pwdata[15:0];
        OFF_START_CFG: start_cfg_reg <= pwdata[5:0];
        OFF_DELAY: delay_reg <= pwdata[15:0];
        OFF_PAUSE_CFG: pause_cfg_reg <= pwdata[4:0];
        OFF_TERM_CFG: term_cfg_reg <= pwdata[NUM_TERM*TERM_CFG_W-1:0];
        OFF_CUSTOM: begin
          custom_n_reg <= pwdata[CUSTOM_N_LSB +: CUSTOM_N_W];
          custom_100k_reg <= pwdata[CUSTOM_CLK_BIT];
        end
        OFF_LINE_DIR: line_dir_reg <= pwdata[NUM_LINES-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // terminal synchronisers and debounce filters

  logic [NUM_TERM-1:0] sync1_reg;
  logic [NUM_TERM-1:0] sync2_reg;
  logic [NUM_TERM-1:0] sync3_reg;
  logic [NUM_TERM-1:0] stable_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      stable_reg <= '0;
    end else if (clk_en) begin
      sync1_reg <= term_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < NUM_TERM; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          stable_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_TERM; g++) begin : g_filt
      logic [CUSTOM_N_W-1:0] cnt_reg;
      logic [CUSTOM_N_W-1:0] n_need;
      logic tick;
      logic slow;
      assign slow = (term_cfg_reg[g].setting == FS_LONG) ||
                    ((term_cfg_reg[g].setting == FS_CUSTOM) && custom_100k_reg);
      assign tick = slow ? tb_100k_tick : tb_80m_tick;
      always_comb begin
        case (term_cfg_reg[g].setting)
          FS_SHORT: n_need = FLT_N_SHORT;
          FS_MEDIUM: n_need = FLT_N_MEDIUM;
          FS_LONG: n_need = FLT_N_LONG;
          default: n_need = custom_n_reg;
        endcase
      end
      // the count restarts whenever the sample matches the output, so a
      // glitch back to the old level throws away the partial qualification
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_reg <= '0;
          filt_reg[g] <= 1'b0;
        end else if (clk_en) begin
          if (!term_cfg_reg[g].filt_en) begin
            cnt_reg <= '0;
            filt_reg[g] <= stable_reg[g];
          end else if (tick) begin
            if (stable_reg[g] == filt_reg[g]) begin
              cnt_reg <= '0;
            end else if (cnt_reg + 10'h001 >= n_need) begin
              cnt_reg <= '0;
              filt_reg[g] <= stable_reg[g];
            end else begin
              cnt_reg <= cnt_reg + 10'h001;
            end
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // clock, start and pause source selection

  logic clk_sig;
  logic clk_prev_reg;
  logic ext_edge;
  logic tb_tick;
  logic tb_prev_reg;
  logic trig_sig;
  logic trig_prev_reg;
  logic trig_edge;
  logic pause_sig;
  logic internal_clk;

  assign internal_clk = (clk_cfg_reg.src == CS_DIV);

  always_comb begin
    case (clk_cfg_reg.src)
      CS_TERM: clk_sig = filt_reg[clk_cfg_reg.term];
      CS_ANALOG: clk_sig = analog_cmp_event;
      CS_CTR: clk_sig = ctr_internal_out;
      default: clk_sig = 1'b0;
    endcase
  end

  always_comb begin
    case (clk_cfg_reg.tb)
      TB_20M: tb_tick = tb_20m_tick;
      TB_80M: tb_tick = tb_80m_tick;
      TB_100K: tb_tick = tb_100k_tick;
      default: tb_tick = stable_reg[clk_cfg_reg.term] && !tb_prev_reg;
    endcase
  end

  always_comb begin
    case (start_cfg_reg.src)
      SS_TERM: trig_sig = filt_reg[start_cfg_reg.term];
      SS_AI_REF: trig_sig = ai_ref_trig;
      SS_AI_START: trig_sig = ai_start_trig;
      SS_ANALOG: trig_sig = analog_cmp_event;
      default: trig_sig = 1'b0;
    endcase
  end

  always_comb begin
    case (pause_cfg_reg.src)
      PS_TERM: pause_sig = filt_reg[pause_cfg_reg.term];
      PS_ANALOG: pause_sig = analog_cmp_event;
      PS_CTR: pause_sig = ctr_internal_out;
      default: pause_sig = 1'b0;
    endcase
  end

  assign ext_edge = clk_sig && !clk_prev_reg;
  assign trig_edge = start_cfg_reg.fall_edge ? (trig_prev_reg && !trig_sig)
                                             : (!trig_prev_reg && trig_sig);
  assign hold_active = (pause_cfg_reg.src != PS_NONE) &&
                       (pause_sig ^ pause_cfg_reg.pause_low);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_reg <= 1'b0;
      tb_prev_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else if (clk_en) begin
      clk_prev_reg <= clk_sig;
      tb_prev_reg <= stable_reg[clk_cfg_reg.term];
      trig_prev_reg <= trig_sig;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // generation sequencer

  dotpf_state_t state_next;
  logic begin_evt;
  logic [15:0] delay_cnt_reg;
  logic [15:0] div_cnt_reg;
  logic [15:0] div_last;
  logic hold_prev_reg;
  logic div_tick;
  logic resume_tick;
  logic update_evt;
  logic delay_done;

  always_comb begin
    case (start_cfg_reg.src)
      SS_NONE: begin_evt = sw_start_cmd;
      SS_HOST: begin_evt = host_trig;
      default: begin_evt = trig_edge;
    endcase
  end

  assign delay_done = tb_tick && (delay_cnt_reg + 16'h0001 >= delay_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (arm_cmd) state_next = ST_WAIT;
      ST_WAIT: begin
        if (begin_evt) begin
          if (internal_clk && (delay_reg != 16'h0000)) begin
            state_next = ST_DELAY;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_DELAY: if (delay_done) state_next = ST_RUN;
      ST_RUN: ;
      default: state_next = ST_IDLE;
    endcase
    if (stop_cmd) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      if (state_reg != ST_DELAY) begin
        delay_cnt_reg <= 16'h0000;
      end else if (tb_tick) begin
        delay_cnt_reg <= delay_cnt_reg + 16'h0001;
      end
    end
  end

  // a zero divisor behaves as one rather than stalling the generation
  assign div_last = (divisor_reg == 16'h0000) ? 16'h0000 : divisor_reg - 16'h0001;
  assign div_tick = tb_tick && (div_cnt_reg >= div_last);
  assign resume_tick = internal_clk && hold_prev_reg && !hold_active;

  // the divider is held cleared while paused so release restarts its phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= 16'h0000;
      hold_prev_reg <= 1'b0;
    end else if (clk_en) begin
      hold_prev_reg <= hold_active;
      if ((state_reg != ST_RUN) || hold_active) begin
        div_cnt_reg <= 16'h0000;
      end else if (tb_tick) begin
        div_cnt_reg <= div_tick ? 16'h0000 : div_cnt_reg + 16'h0001;
      end
    end
  end

  // samples are single-cycle, so gating the event itself lets any sample
  // already issued finish while the next one is suppressed
  assign update_evt = (state_reg == ST_RUN) && !stop_cmd && !hold_active &&
                      (internal_clk ? (div_tick || resume_tick) : ext_edge);

  ////////////////////////////////////////////////////////////////////////
  // outputs

  logic update_pulse_reg;
  logic begin_pulse_reg;
  logic [NUM_TERM-1:0] term_out_reg;
  logic [NUM_LINES-1:0] line_out_reg;
  logic [NUM_TERM-1:0] term_next;
  logic begin_now;

  assign begin_now = (state_reg == ST_WAIT) && begin_evt && !stop_cmd;

  always_comb begin
    for (int i = 0; i < NUM_TERM; i++) begin
      case (term_cfg_reg[i].out_sel)
        OS_UPDATE: term_next[i] = update_evt;
        OS_BEGIN: term_next[i] = begin_now;
        default: term_next[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      update_pulse_reg <= 1'b0;
      begin_pulse_reg <= 1'b0;
      term_out_reg <= '0;
    end else if (clk_en) begin
      update_pulse_reg <= update_evt;
      begin_pulse_reg <= begin_now;
      term_out_reg <= term_next;
    end
  end

  // line values live apart from the direction bits, so rewriting direction
  // never disturbs a level already being driven
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_out_reg <= '0;
      sample_cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      if (update_evt) begin
        line_out_reg <= sample_data;
        sample_cnt_reg <= sample_cnt_reg + 16'h0001;
      end else if (arm_cmd && (state_reg == ST_IDLE)) begin
        sample_cnt_reg <= 16'h0000;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_TERM; i++) begin
      term_oe_n[i] = (term_cfg_reg[i].out_sel == OS_INPUT) ||
                     (term_cfg_reg[i].out_sel == 2'b11);
    end
  end

  assign term_out = term_out_reg;
  assign line_out = line_out_reg;
  assign line_oe_n = ~line_dir_reg;
  assign sample_taken = update_pulse_reg;
  assign begin_pulse = begin_pulse_reg;

endmodule

`default_nettype wire

// ==== bench/dotpf_properties.sv ====
/*
  Port-level checks for the output timing block.
  Assumes one core clock domain and the package constants.
*/
`timescale 1ns/10ps
`default_nettype none

module dotpf_properties
  import dotpf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_LINES-1:0] sample_data,
  input wire logic sample_taken,
  input wire logic [NUM_LINES-1:0] line_out,
  input wire logic [NUM_LINES-1:0] line_oe_n,
  input wire logic [NUM_TERM-1:0] term_oe_n,
  input wire logic begin_pulse
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] wd_lo;
  logic wr;
  logic stop_wr;
  assign wd_lo = pwdata[7:0];
  assign wr = psel && penable && pwrite && clk_en;
  assign stop_wr = wr && paddr == OFF_CTRL && pwdata[CTRL_STOP_BIT];
  ////////////////////////////////////////
  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_err_access_only: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_err_unmapped: assert property (psel && penable && paddr[1:0] == 2'b00
    |-> pslverr == (paddr > OFF_STATUS)) else $error("pslverr decode wrong");
  a_dir_applied: assert property (wr && paddr == OFF_LINE_DIR
    |=> line_oe_n == ~$past(wd_lo)) else $error("line direction not applied");
  a_line_hold: assert property ($changed(line_out) |-> sample_taken)
    else $error("line_out moved without a sample");
  a_line_data: assert property (sample_taken |-> line_out == $past(sample_data))
    else $error("line_out is not the sampled data");
  a_begin_single: assert property (begin_pulse |=> !begin_pulse)
    else $error("begin pulse longer than one cycle");
  a_stop_quiet: assert property (stop_wr |=> !sample_taken [*3])
    else $error("sample after stop");
  a_reset_outputs: assert property ($rose(rst_n)
    |-> term_oe_n == 4'hF && line_oe_n == 8'hFF) else $error("reset drive state");
  c_begin: cover property (begin_pulse);
  c_sample: cover property (sample_taken ##1 !sample_taken);
  c_unmapped: cover property (pslverr);
endmodule

bind dotpf_timing dotpf_properties i_props (.*);
`default_nettype wire

// ==== bench/dotpf_far_model.sv ====
/*
  Far-side terminal wiring: external levels on the programmable terminals.
  Assumes callers step it right after a rising core clock edge.
*/
`timescale 1ns/10ps
`default_nettype none

module dotpf_far_model
  import dotpf_pkg::*;
(
  input wire logic core_clk,
  input wire logic [NUM_TERM-1:0] term_out,
  input wire logic [NUM_TERM-1:0] term_oe_n,
  output logic [NUM_TERM-1:0] term_in
);
  logic [NUM_TERM-1:0] ext_lvl = '0;
  ////////////////////////////////////////
  // a terminal the device drives shows its level, the wiring yields to it
  assign term_in = (~term_oe_n & term_out) | (term_oe_n & ext_lvl);
  task automatic drive(input int i, input logic v, input int n);
    ext_lvl[i] <= v;
    repeat (n) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ==== bench/test_dotpf_timing.sv ====
/*
  Directed bench for the output timing block over APB.
  Assumes 80 MHz ticks on every core cycle, so filter counts are cycles.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end

module test_dotpf_timing
  import dotpf_pkg::*;
  ;
  logic core_clk, rst_n = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, rerr, lvl;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic tb_20m_tick = 1'b0, tb_80m_tick = 1'b1, tb_100k_tick = 1'b0;
  logic analog_cmp_event = 1'b0, ctr_internal_out = 1'b0;
  logic ai_ref_trig = 1'b0, ai_start_trig = 1'b0, sample_taken, begin_pulse;
  logic [NUM_TERM-1:0] term_in, term_out, term_oe_n;
  logic [NUM_LINES-1:0] sample_data = '0, line_out, line_oe_n;
  int num_errors = 0, cmp_count = 0, nsamp = 0, nbeg = 0, nupd = 0, nbt = 0;
  int waited, n0, b0, u0, t0;
  int gap [2];

  dotpf_timing i_dut (.*);
  dotpf_far_model i_far (
    .core_clk(core_clk),
    .term_out(term_out),
    .term_oe_n(term_oe_n),
    .term_in(term_in)
  );
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    sample_data <= sample_data + 8'h01;
  end
  // counting on the falling edge keeps the waits free of edge races
  always @(negedge core_clk) begin
    nsamp += (sample_taken === 1'b1);
    nbeg += (begin_pulse === 1'b1);
    nupd += (term_out[3] === 1'b1);
    nbt += (term_out[2] === 1'b1);
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rdat)
  endtask
  task automatic wait_for(ref int c, input int v);
    waited = 0;
    while (c < v && waited < 400) begin
      @(posedge core_clk);
      waited++;
    end
    if (c < v) num_errors++;
  endtask
  // every edge start source (terminal 0, AI ref, AI start, analog) moves together; only the selected one may count
  task automatic set_src(input logic v);
    ai_ref_trig <= v;
    ai_start_trig <= v;
    analog_cmp_event <= v;
    i_far.drive(0, v, 8);
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #200us;
    num_errors++;
    results();
  end
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    `CHK("term_oe_n", 4'hF, term_oe_n)
    rd("clk_cfg", OFF_CLK_CFG, 32'h0000000F);
    rd("divisor", OFF_DIVISOR, 32'h00000001);
    rd("term_cfg", OFF_TERM_CFG, 32'h00000000);
    rd("custom", OFF_CUSTOM, 32'h00000001);
    rd("status", OFF_STATUS, 32'h00000000);
    rd("unmapped", 12'h040, 32'h00000000);
    `CHK("pslverr", 1'b1, rerr)
    $display("test reset done");
    wr(OFF_CLK_CFG, 32'h07);
    wr(OFF_DIVISOR, 32'h03);
    for (int k = 0; k < 2; k++) begin
      wr(OFF_CTRL, 32'h4);
      wr(OFF_DELAY, 32'(k * 5));
      wr(OFF_CTRL, 32'h1);
      n0 = nsamp;
      b0 = nbeg;
      wr(OFF_CTRL, 32'h2);
      wait_for(nsamp, n0 + 1);
      gap[k] = waited;
      `CHK("begin", b0 + 1, nbeg)
    end
    `CHK("delay", gap[0] + 5, gap[1])
    n0 = nsamp;
    wait_for(nsamp, n0 + 1);
    wait_for(nsamp, n0 + 2);
    `CHK("period", 3, waited)
    for (int pl = 0; pl < 2; pl++) begin
      wr(OFF_PAUSE_CFG, 32'(pl * 4 + 2));
      analog_cmp_event <= (pl == 0);
      repeat (3) @(posedge core_clk);
      n0 = nsamp;
      repeat (20) @(posedge core_clk);
      `CHK("paused", n0, nsamp)
      analog_cmp_event <= (pl != 0);
      wait_for(nsamp, n0 + 1);
      `CHK("resume", 1'b1, waited <= 3)
    end
    $display("test divider done");
    wr(OFF_CTRL, 32'h4);
    wr(OFF_PAUSE_CFG, 32'h0);
    wr(OFF_CLK_CFG, 32'h10);
    wr(OFF_TERM_CFG, 32'h44020);
    wr(OFF_START_CFG, 32'h1);
    `CHK("term_oe_n", 4'h3, term_oe_n)
    wr(OFF_CTRL, 32'h1);
    b0 = nbeg;
    t0 = nbt;
    wr(OFF_CTRL, 32'h8);
    wait_for(nbeg, b0 + 1);
    repeat (2) @(posedge core_clk);
    `CHK("begin_out", t0 + 1, nbt)
    n0 = nsamp;
    u0 = nupd;
    i_far.drive(1, 1'b1, 8);
    i_far.drive(1, 1'b0, 20);
    `CHK("glitch", n0, nsamp)
    i_far.drive(1, 1'b1, 20);
    i_far.drive(1, 1'b0, 4);
    i_far.drive(1, 1'b1, 20);
    i_far.drive(1, 1'b0, 20);
    `CHK("filtered", n0 + 1, nsamp)
    `CHK("upd_out", u0 + 1, nupd)
    wr(OFF_PAUSE_CFG, 32'h2);
    analog_cmp_event <= 1'b1;
    i_far.drive(1, 1'b1, 20);
    i_far.drive(1, 1'b0, 20);
    analog_cmp_event <= 1'b0;
    repeat (10) @(posedge core_clk);
    `CHK("ext_pause", n0 + 1, nsamp)
    i_far.drive(1, 1'b1, 20);
    i_far.drive(1, 1'b0, 20);
    `CHK("ext_resume", n0 + 2, nsamp)
    wr(OFF_LINE_DIR, 32'hA5);
    `CHK("line_oe_n", 8'h5A, line_oe_n)
    wr(OFF_CUSTOM, 32'h14);
    wr(OFF_TERM_CFG, 32'h440E0);
    i_far.drive(1, 1'b1, 19);
    i_far.drive(1, 1'b0, 30);
    i_far.drive(1, 1'b1, 20);
    i_far.drive(1, 1'b0, 30);
    `CHK("custom", n0 + 3, nsamp)
    $display("test terminal clock done");
    wr(OFF_PAUSE_CFG, 32'h0);
    for (int s = 2; s < 6; s++) begin
      wr(OFF_CTRL, 32'h4);
      lvl = (s % 2 == 0);
      set_src(lvl);
      wr(OFF_START_CFG, 32'(s + 8 * (s % 2)));
      wr(OFF_CTRL, 32'h1);
      b0 = nbeg;
      set_src(!lvl);
      repeat (4) @(posedge core_clk);
      `CHK("wrong_edge", b0, nbeg)
      set_src(lvl);
      wait_for(nbeg, b0 + 1);
      `CHK("start_edge", b0 + 1, nbeg)
    end
    $display("test start sources done");
    wr(OFF_START_CFG, 32'h0);
    for (int c = 1; c < 3; c++) begin
      wr(OFF_CTRL, 32'h4);
      wr(OFF_CLK_CFG, 32'(c));
      wr(OFF_CTRL, 32'h1);
      wr(OFF_CTRL, 32'h2);
      n0 = nsamp;
      repeat (3) begin
        analog_cmp_event <= 1'b1;
        ctr_internal_out <= 1'b1;
        repeat (3) @(posedge core_clk);
        analog_cmp_event <= 1'b0;
        ctr_internal_out <= 1'b0;
        repeat (3) @(posedge core_clk);
      end
      `CHK("ext_clk", n0 + 3, nsamp)
    end
    $display("test clock sources done");
    results();
  end
endmodule
`default_nettype wire
